// ---- design/xsr_defines.svh ----
`ifndef XSR_DEFINES_SVH
`define XSR_DEFINES_SVH

// Returned and received word layout
`define XSR_WORD_W        16
`define XSR_WD_BIT        15
`define XSR_CODE_HI       14
`define XSR_CODE_LO       10
`define XSR_NM_BIT        9
`define XSR_PAYLOAD_HI    8
`define XSR_POR_BIT       8

// Command fields of a received word
`define XSR_CMD_IDX_HI    14
`define XSR_CMD_IDX_LO    13
`define XSR_CMD_ADDR_HI   12
`define XSR_CMD_ADDR_LO   10
`define XSR_CMD_SEL_HI    4

// Command addresses
`define XSR_ADDR_SELECT   3'h0
`define XSR_ADDR_DUTY     3'h1
`define XSR_ADDR_SETUP_A  3'h2
`define XSR_ADDR_SETUP_B  3'h3
`define XSR_ADDR_LIMIT    3'h4
`define XSR_ADDR_GLOBAL   3'h5

// Readback codes: low three bits per output, full codes otherwise
`define XSR_SRC_STATUS    3'h0
`define XSR_SRC_DUTY      3'h1
`define XSR_SRC_SETUP_A   3'h2
`define XSR_SRC_SETUP_B   3'h3
`define XSR_SRC_LIMIT     3'h4
`define XSR_CODE_GLOBAL   5'h05
`define XSR_CODE_DIAG_A   5'h07
`define XSR_CODE_DIAG_B   5'h0f
`define XSR_CODE_PART     5'h17

// Masks that force unused positions to zero on readback
`define XSR_MASK_DUTY     9'h0ff
`define XSR_MASK_SETUP_A  9'h03f
`define XSR_MASK_SETUP_B  9'h07f
`define XSR_MASK_LIMIT    9'h0ff
`define XSR_MASK_GLOBAL   9'h1fd

// Reset values
`define XSR_CODE_RST      5'h00
`define XSR_CFG_RST       9'h000
`define XSR_GLOBAL_RST    9'h000
`define XSR_WORD_RST      16'h0000

// Product code; value is arbitrary apart from its top bit
`define XSR_PART_CODE     3'h5

`endif

// ---- design/xsr_pkg.sv ----
package xsr_pkg;

   typedef enum logic [2:0] {
      XSR_ST_IDLE   = 3'b001,
      XSR_ST_SHIFT  = 3'b010,
      XSR_ST_COMMIT = 3'b100
   } xsr_state_t;

   typedef struct packed {
      logic [8:0] duty;
      logic [8:0] setup_a;
      logic [8:0] setup_b;
      logic [8:0] limit;
   } xsr_chan_cfg_t;

   // Order matches returned bits 5 down to 0 of the status source
   typedef struct packed {
      logic lamp_open_while_driven;
      logic lamp_open_while_idle;
      logic shorted_to_battery_fault;
      logic thermal_fault;
      logic hard_short_fault;
      logic excess_current_fault;
   } xsr_fault_t;

   typedef struct packed {
      logic clock_fail;
      logic cal_fail;
      logic thermal_prewarning;
   } xsr_diag_t;

endpackage : xsr_pkg

// ---- design/xsr_readback.sv ----
`timescale 1ns/10ps
`include "xsr_defines.svh"

// How it works
// (R1) Top returned bit echoes previous watchdog toggle
// (R2) Next five bits echo readback selection code
// (R3) Bit 9 high only in normal mode
// (R4) Low nine bits from latest selector write
// (R5) Low code bits pick source, top pick output
// (R6) Code 00101 returns global setup register
// (R7) Bit 8 power-up flag, cleared by reading
// (R8) Bits 7..6 report supply faults, bits 5..0 addressed output faults
// (R9) Fault pin shows faults; latched ones until toggle
// (R10) Code 00111 bit 2: reference clock out-of-range
// (R11) Same source bit 1: calibration failed
// (R12) Same source bit 0: thermal prewarning
// (R13) Code 01111 bits 4..1: live parallel inputs
// (R14) Same source bit 0: watchdog enabled
// (R15) In fail-safe those bits show output states
// (R16) Code 10111 returns product pattern, top bit one
// (R17) Reset selects output 0 status, default setups
// (R18) Reset leaves retry, detections, overvoltage protection on
// (R19) Reset leaves recopy, feedback, supply detector off
// (R20) Word loaded at select fall, shifted MSB first
// (R21) Frames not multiple of 16 bits ignored
// (R22) Held word resets to zero; it is reloaded at select fall before it is sent
// (R23) Unused returned positions driven zero
module xsr_readback (
   // System clock and reset
   input  wire logic                      sys_clk_in,
   input  wire logic                      rst_in,
   // Serial link pins
   input  wire logic                      spi_sck_in,
   input  wire logic                      spi_cs_n_in,
   input  wire logic                      spi_mosi_in,
   output logic                           spi_miso_out,
   output logic                           spi_miso_oe_n_out,
   // Device state from the surrounding logic, same clock
   input  wire logic                      normal_mode_flag_in,
   input  wire logic                      supply_low_fault_in,
   input  wire logic                      supply_high_fault_in,
   input  xsr_pkg::xsr_fault_t [3:0]      fault_register_in,
   input  wire logic [3:0]                fault_control_in,
   input  xsr_pkg::xsr_diag_t             diag_in,
   input  wire logic                      watchdog_active_in,
   input  wire logic                      failsafe_in,
   input  wire logic [3:0]                failsafe_outputs_in,
   // Asynchronous pins
   input  wire logic [3:0]                parallel_in,
   input  wire logic                      supply_por_in,
   // Settings and fault pin
   output xsr_pkg::xsr_chan_cfg_t [3:0]   chan_cfg_out,
   output logic [8:0]                     global_setup_reg_out,
   output logic                           fault_flag_pin_n_out
);

   // Link domain: runs only on the host's clock, held clear between frames
   logic [4:0]              lk_cnt;
   logic [4:0]              next_lk_cnt;
   logic [4:0]              lk_gray;
   logic [4:0]              next_lk_gray;
   logic [15:0]             lk_shift;
   logic [15:0]             next_lk_shift;
   logic                    lk_done;
   logic                    next_lk_done;
   logic                    lk_clr;

   always_comb begin
      // Count crosses as gray code: a sample taken mid-step is off by one
      next_lk_cnt   = lk_cnt + 5'h01;
      next_lk_gray  = next_lk_cnt ^ {1'b0, next_lk_cnt[4:1]};
      next_lk_shift = {lk_shift[14:0], spi_mosi_in};
      next_lk_done  = lk_done | (lk_cnt[3:0] == 4'hf);
   end

   // Clear is a system flop that releases a few cycles after select falls;
   // the host must allow at least 20 ns from select low to the first edge
   always_ff @(posedge spi_sck_in or posedge lk_clr) begin
      if (lk_clr) begin
         lk_cnt   <= 5'h00;
         lk_gray  <= 5'h00;
         lk_shift <= 16'h0000;
         lk_done  <= 1'b0;
      end else begin
         lk_cnt   <= next_lk_cnt;
         lk_gray  <= next_lk_gray;
         lk_shift <= next_lk_shift;
         lk_done  <= next_lk_done;
      end
   end

   // Synchronisers into the system domain
   logic                    cs_meta;
   logic                    cs_sync;
   logic                    cs_prev;
   logic [4:0]              gray_meta;
   logic [4:0]              gray_sync;
   logic [3:0]              par_meta;
   logic [3:0]              par_sync;
   logic                    por_meta;
   logic                    por_sync;

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         cs_meta   <= 1'b1;
         cs_sync   <= 1'b1;
         cs_prev   <= 1'b1;
         gray_meta <= 5'h00;
         gray_sync <= 5'h00;
         par_meta  <= 4'h0;
         par_sync  <= 4'h0;
         por_meta  <= 1'b0;
         por_sync  <= 1'b0;
      end else begin
         cs_meta   <= spi_cs_n_in;
         cs_sync   <= cs_meta;
         cs_prev   <= cs_sync;
         gray_meta <= lk_gray;
         gray_sync <= gray_meta;
         par_meta  <= parallel_in;
         par_sync  <= par_meta;
         por_meta  <= supply_por_in;
         por_sync  <= por_meta;
      end
   end

   function automatic logic [4:0] xsr_gray2bin(input logic [4:0] g);
      logic [4:0] b;
      b[4] = g[4];
      for (int i = 3; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction : xsr_gray2bin

   // Frame control, stored settings and returned word
   xsr_pkg::xsr_state_t     state;
   xsr_pkg::xsr_state_t     next_state;
   logic                    next_lk_clr;
   logic [15:0]             tx_word;
   logic [15:0]             next_tx_word;
   logic [4:0]              readback_code;
   logic [4:0]              next_readback_code;
   logic [4:0]              frame_code;
   logic [4:0]              next_frame_code;
   logic                    watchdog_toggle;
   logic                    next_watchdog_toggle;
   logic                    power_up_flag;
   logic                    next_power_up_flag;
   xsr_pkg::xsr_chan_cfg_t [3:0] next_chan_cfg;
   logic [8:0]              next_global_setup;
   logic                    next_miso;
   logic                    next_miso_oe_n;
   logic [8:0]              payload;
   logic [4:0]              bit_cnt;
   logic [3:0]              bit_idx;
   logic                    frame_valid;
   logic [2:0]              cmd_addr;
   logic [1:0]              cmd_idx;
   logic [1:0]              out_sel;
   logic                    status_read;

   always_comb begin
      next_state           = state;
      next_lk_clr          = lk_clr;
      next_tx_word         = tx_word;
      next_readback_code   = readback_code;
      next_frame_code      = frame_code;
      next_watchdog_toggle = watchdog_toggle;
      next_power_up_flag   = power_up_flag;
      next_chan_cfg        = chan_cfg_out;
      next_global_setup    = global_setup_reg_out;
      cmd_addr = lk_shift[`XSR_CMD_ADDR_HI:`XSR_CMD_ADDR_LO];
      cmd_idx  = lk_shift[`XSR_CMD_IDX_HI:`XSR_CMD_IDX_LO];
      out_sel  = readback_code[4:3];
      bit_cnt  = xsr_gray2bin(gray_sync);
      bit_idx  = 4'hf - bit_cnt[3:0];
      // Link regs are quiet here: sck stopped and select is high
      frame_valid = lk_done && (bit_cnt[3:0] == 4'h0); // see (R21)
      // Every output's status word carries the flag, so each read clears it
      status_read = (frame_code[2:0] == `XSR_SRC_STATUS);

      payload = 9'h000; // see (R23)
      if (readback_code == `XSR_CODE_GLOBAL) begin
         payload = global_setup_reg_out & `XSR_MASK_GLOBAL; // see (R6)
      end else if (readback_code == `XSR_CODE_DIAG_A) begin
         payload = {6'h00, diag_in.clock_fail, // see (R10)
                    diag_in.cal_fail, // see (R11)
                    diag_in.thermal_prewarning}; // see (R12)
      end else if (readback_code == `XSR_CODE_DIAG_B) begin
         // Pins pass the synchroniser first, so they show two cycles late
         if (failsafe_in) begin
            payload = {4'h0, failsafe_outputs_in, // see (R15)
                       watchdog_active_in};
         end else begin
            payload = {4'h0, par_sync, // see (R13)
                       watchdog_active_in}; // see (R14)
         end
      end else if (readback_code == `XSR_CODE_PART) begin
         payload = {6'h00, `XSR_PART_CODE}; // see (R16)
      end else begin
         case (readback_code[2:0]) // see (R5)
            `XSR_SRC_STATUS: begin
               payload = {power_up_flag, // see (R7)
                          supply_low_fault_in, // see (R8)
                          supply_high_fault_in,
                          fault_register_in[out_sel]};
            end
            `XSR_SRC_DUTY: begin
               payload = chan_cfg_out[out_sel].duty & `XSR_MASK_DUTY;
            end
            `XSR_SRC_SETUP_A: begin
               payload = chan_cfg_out[out_sel].setup_a & `XSR_MASK_SETUP_A;
            end
            `XSR_SRC_SETUP_B: begin
               payload = chan_cfg_out[out_sel].setup_b & `XSR_MASK_SETUP_B;
            end
            `XSR_SRC_LIMIT: begin
               payload = chan_cfg_out[out_sel].limit & `XSR_MASK_LIMIT;
            end
            default: begin
               payload = 9'h000;
            end
         endcase
      end

      next_miso      = 1'b0;
      next_miso_oe_n = 1'b1;
      case (state)
         xsr_pkg::XSR_ST_IDLE: begin
            if (cs_prev && !cs_sync) begin
               next_tx_word    = {watchdog_toggle, // see (R1)
                                  readback_code, // see (R2)
                                  normal_mode_flag_in, // see (R3)
                                  payload}; // see (R4) (R20)
               next_frame_code = readback_code;
               next_lk_clr     = 1'b0;
               next_state      = xsr_pkg::XSR_ST_SHIFT;
            end
         end
         xsr_pkg::XSR_ST_SHIFT: begin
            next_miso_oe_n = 1'b0;
            // MSB first; bits 16 to 31 are held low, then the count wraps and the word repeats
            next_miso = bit_cnt[4] ? 1'b0 : tx_word[bit_idx]; // see (R20)
            if (cs_sync) begin
               next_miso_oe_n = 1'b1;
               next_miso      = 1'b0;
               next_state     = xsr_pkg::XSR_ST_COMMIT;
            end
         end
         xsr_pkg::XSR_ST_COMMIT: begin
            if (frame_valid) begin // see (R21)
               next_watchdog_toggle = lk_shift[`XSR_WD_BIT]; // see (R1)
               if (status_read) begin
                  next_power_up_flag = 1'b0; // see (R7)
               end
               case (cmd_addr)
                  `XSR_ADDR_SELECT: begin
                     next_readback_code =
                        lk_shift[`XSR_CMD_SEL_HI:0]; // see (R4)
                  end
                  `XSR_ADDR_DUTY: begin
                     next_chan_cfg[cmd_idx].duty = lk_shift[8:0];
                  end
                  `XSR_ADDR_SETUP_A: begin
                     next_chan_cfg[cmd_idx].setup_a = lk_shift[8:0];
                  end
                  `XSR_ADDR_SETUP_B: begin
                     next_chan_cfg[cmd_idx].setup_b = lk_shift[8:0];
                  end
                  `XSR_ADDR_LIMIT: begin
                     next_chan_cfg[cmd_idx].limit = lk_shift[8:0];
                  end
                  `XSR_ADDR_GLOBAL: begin
                     if (cmd_idx == 2'h0) begin
                        next_global_setup = lk_shift[8:0];
                     end
                  end
                  default: begin
                     next_global_setup = global_setup_reg_out;
                  end
               endcase
            end
            next_lk_clr = 1'b1;
            next_state  = xsr_pkg::XSR_ST_IDLE;
         end
         default: begin
            next_lk_clr = 1'b1;
            next_state  = xsr_pkg::XSR_ST_IDLE;
         end
      endcase
      // A power-on event beats a read in the same cycle
      if (por_sync) begin
         next_power_up_flag = 1'b1; // see (R7)
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         state                <= xsr_pkg::XSR_ST_IDLE;
         lk_clr               <= 1'b1;
         tx_word              <= `XSR_WORD_RST; // see (R22)
         readback_code        <= `XSR_CODE_RST; // see (R17)
         frame_code           <= `XSR_CODE_RST;
         watchdog_toggle      <= 1'b0;
         power_up_flag        <= 1'b1; // see (R7)
         // All-zero settings: default slew, detections and retry on,
         // recopy, feedback and supply detector off
         for (int i = 0; i < 4; i++) begin
            chan_cfg_out[i].duty    <= `XSR_CFG_RST;
            chan_cfg_out[i].setup_a <= `XSR_CFG_RST; // see (R17)
            chan_cfg_out[i].setup_b <= `XSR_CFG_RST; // see (R18)
            chan_cfg_out[i].limit   <= `XSR_CFG_RST;
         end
         global_setup_reg_out <= `XSR_GLOBAL_RST; // see (R18) (R19)
         spi_miso_out         <= 1'b0;
         spi_miso_oe_n_out    <= 1'b1;
      end else begin
         state                <= next_state;
         lk_clr               <= next_lk_clr;
         tx_word              <= next_tx_word;
         readback_code        <= next_readback_code;
         frame_code           <= next_frame_code;
         watchdog_toggle      <= next_watchdog_toggle;
         power_up_flag        <= next_power_up_flag;
         chan_cfg_out         <= next_chan_cfg;
         global_setup_reg_out <= next_global_setup;
         spi_miso_out         <= next_miso;
         spi_miso_oe_n_out    <= next_miso_oe_n;
      end
   end

   // Fault pin: short, thermal and excess-current faults latch per output
   logic [3:0]              fault_latch;
   logic [3:0]              next_fault_latch;
   logic [3:0]              ctrl_prev;
   logic                    next_fault_pin_n;
   logic                    live_any;

   always_comb begin
      live_any = supply_low_fault_in | supply_high_fault_in;
      for (int i = 0; i < 4; i++) begin
         live_any = live_any | (|fault_register_in[i]);
         next_fault_latch[i] = fault_latch[i];
         if (fault_control_in[i] != ctrl_prev[i]) begin
            next_fault_latch[i] = 1'b0; // see (R9)
         end
         // A new fault wins over a clearing toggle in the same cycle
         if (fault_register_in[i].hard_short_fault |
             fault_register_in[i].thermal_fault |
             fault_register_in[i].excess_current_fault) begin
            next_fault_latch[i] = 1'b1; // see (R9)
         end
      end
      // Supply faults never latch; they show only while present
      next_fault_pin_n = !(live_any | (|fault_latch)); // see (R9)
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         fault_latch          <= 4'h0;
         ctrl_prev            <= 4'h0;
         fault_flag_pin_n_out <= 1'b1;
      end else begin
         fault_latch          <= next_fault_latch;
         ctrl_prev            <= fault_control_in;
         fault_flag_pin_n_out <= next_fault_pin_n;
      end
   end

endmodule : xsr_readback

// ---- tb/xsr_host.sv ----
`timescale 1ns/10ps
module xsr_host (
   // Link pins driven by the host
   output logic      spi_sck_out,
   output logic      spi_cs_n_out,
   output logic      spi_mosi_out,
   // Returned data line
   input  wire logic spi_miso_in
);
   initial begin
      spi_sck_out  = 1'h0;
      spi_cs_n_out = 1'h1;
      spi_mosi_out = 1'h0;
   end

   // Clock runs only inside frames; data set after falling sck
   task automatic frame(input logic [47:0] tx, input int n,
                        output logic [15:0] rx);
      int k;
      rx = '0;
      spi_cs_n_out = 1'h0;
      #25;  // Setup past 20 ns, off the system clock grid
      for (k = 0; k < n; k++) begin
         spi_mosi_out = tx[n-1-k];
         #16 spi_sck_out = 1'h1;
         if (k < 16) begin
            rx[15-k] = spi_miso_in;
         end
         #16 spi_sck_out = 1'h0;
      end
      #16 spi_cs_n_out = 1'h1;
      spi_mosi_out = ~spi_mosi_out;  // Released line must not hold last bit
      #48;
   endtask : frame
endmodule : xsr_host

// ---- tb/xsr_readback_checker.sv ----
`timescale 1ns/10ps
module xsr_readback_checker (
   // Clock and reset
   input  wire logic                    sys_clk_in,
   input  wire logic                    rst_in,
   // Link pins
   input  wire logic                    spi_cs_n_in,
   input  wire logic                    spi_miso_out,
   input  wire logic                    spi_miso_oe_n_out,
   // Fault sources
   input  wire logic                    supply_low_fault_in,
   input  wire logic                    supply_high_fault_in,
   input  xsr_pkg::xsr_fault_t [3:0]    fault_register_in,
   // Settings and fault pin
   input  xsr_pkg::xsr_chan_cfg_t [3:0] chan_cfg_out,
   input  wire logic [8:0]              global_setup_reg_out,
   input  wire logic                    fault_flag_pin_n_out
);
   logic any_flt;

   assign any_flt = supply_low_fault_in | supply_high_fault_in
                    | (|fault_register_in);

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   chk_reset_idle: assert property (disable iff (1'h0)
      rst_in |=> spi_miso_oe_n_out && !spi_miso_out)
      else $error("Link not idle after reset");
   chk_reset_cfg: assert property (disable iff (1'h0)
      rst_in |=> chan_cfg_out == '0 && global_setup_reg_out == 9'h000)
      else $error("Settings not cleared by reset");
   chk_cfg_frame: assert property (
      !spi_cs_n_in |-> $stable(chan_cfg_out)
                       && $stable(global_setup_reg_out))
      else $error("Settings changed inside a frame");
   chk_oe_start: assert property (
      $fell(spi_cs_n_in) |-> ##[2:6] !spi_miso_oe_n_out)
      else $error("Return line not driven after select");
   chk_oe_end: assert property (
      $rose(spi_cs_n_in) |-> ##[1:6] spi_miso_oe_n_out)
      else $error("Return line not released after frame");
   chk_miso_zero: assert property (
      spi_miso_oe_n_out |-> !spi_miso_out)
      else $error("Return data not zero while released");
   chk_pin_live: assert property (
      supply_low_fault_in || supply_high_fault_in
      |-> ##[1:2] !fault_flag_pin_n_out)
      else $error("Fault pin missed a supply fault");
   chk_pin_cause: assert property (
      $fell(fault_flag_pin_n_out) |-> $past(any_flt) || $past(any_flt, 2))
      else $error("Fault pin fell with no fault");
   chk_pin_rise: assert property (
      $rose(fault_flag_pin_n_out) |-> !$past(any_flt))
      else $error("Fault pin released during a fault");

   cover property ($fell(spi_cs_n_in));
   cover property ($fell(fault_flag_pin_n_out));
   cover property (!$stable(chan_cfg_out));
endmodule : xsr_readback_checker

// ---- tb/xsr_readback_test.sv ----
`timescale 1ns/10ps
module xsr_readback_test;
   logic                         sys_clk_in = 1'h0;
   logic                         rst_in     = 1'h1;
   logic                         sck, cs_n, mosi, miso, oe_n, pin_n;
   wire                          so_line;
   logic                         nm = 1'h0, s_low = 1'h0, s_high = 1'h0;
   logic                         wd_act = 1'h0, fs = 1'h0, por = 1'h0;
   logic [3:0]                   f_ctl = 4'h0, fs_out = 4'h0, par = 4'h0;
   xsr_pkg::xsr_fault_t [3:0]    flt  = '0;
   xsr_pkg::xsr_diag_t           diag = '0;
   xsr_pkg::xsr_chan_cfg_t [3:0] cfg;
   logic [8:0]                   gsr;
   int                           err_total = 0;
   int                           checks = 0;
   int                           s;
   logic                         wd = 1'h1, last_wd = 1'h0;
   logic [4:0]                   code = 5'h00;
   logic [6:0]                   hdr;
   logic [15:0]                  rx;
   logic [8:0]                   msk [1:4] = '{9'h0ff, 9'h03f, 9'h07f, 9'h0ff};

   always #2 sys_clk_in = ~sys_clk_in;
   // A released return line floats, so a stray sample never matches
   assign so_line = oe_n ? 1'hz : miso;

   xsr_host u_host (
      .spi_sck_out  (sck),
      .spi_cs_n_out (cs_n),
      .spi_mosi_out (mosi),
      .spi_miso_in  (so_line)
   );

   xsr_readback DUT (
      .sys_clk_in           (sys_clk_in),
      .rst_in               (rst_in),
      .spi_sck_in           (sck),
      .spi_cs_n_in          (cs_n),
      .spi_mosi_in          (mosi),
      .spi_miso_out         (miso),
      .spi_miso_oe_n_out    (oe_n),
      .normal_mode_flag_in  (nm),
      .supply_low_fault_in  (s_low),
      .supply_high_fault_in (s_high),
      .fault_register_in    (flt),
      .fault_control_in     (f_ctl),
      .diag_in              (diag),
      .watchdog_active_in   (wd_act),
      .failsafe_in          (fs),
      .failsafe_outputs_in  (fs_out),
      .parallel_in          (par),
      .supply_por_in        (por),
      .chan_cfg_out         (cfg),
      .global_setup_reg_out (gsr),
      .fault_flag_pin_n_out (pin_n)
   );

   task automatic nx(input int k);
      repeat (k) @(negedge sys_clk_in);
   endtask : nx

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // One frame; the header expected back is the state before it
   task automatic go(input int n, input logic [1:0] idx,
                     input logic [2:0] adr, input logic [8:0] d);
      hdr = {last_wd, code, nm};
      u_host.frame({32'h0000a5c3, wd, idx, adr, 1'h0, d}, n, rx);
      if (n % 16 == 0) begin
         last_wd = wd;
         if (adr == 3'h0) begin
            code = d[4:0];
         end
      end
      wd = ~wd;
   endtask : go

   // Repeat the current selection and compare the returned word
   task automatic rd(input int n, input logic [8:0] p, input logic [8:0] m);
      go(n, 2'h0, 3'h0, {4'h0, code});
      chk(rx & {7'h7f, m}, {hdr, p});
   endtask : rd

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_of_test

   initial begin
      #100000;  // Whole sequence needs about a fifth of this
      err_total++;
      end_of_test();
   end

   initial begin
      nx(12);
      rst_in = 1'h0;
      nx(4);
      chk({14'h0, cfg === '0, gsr === '0}, 16'h0003);
      rd(16, 9'h100, 9'h1ff);
      $display("reset test done");
      nx(1);
      nm     = 1'h1;
      s_low  = 1'h1;
      flt[0] = 6'h2a;
      nx(4);
      chk({15'h0, pin_n}, 16'h0000);
      rd(16, 9'h0aa, 9'h1ff);
      nx(1);
      s_low  = 1'h0;
      flt[0] = 6'h00;
      nx(4);
      chk({15'h0, pin_n}, 16'h0000);
      f_ctl[0] = 1'h1;
      nx(4);
      chk({15'h0, pin_n}, 16'h0001);
      // Status of output 3 must clear the power-up flag as well
      go(16, 2'h0, 3'h0, 9'h018);
      nx(1);
      por    = 1'h1;
      s_high = 1'h1;
      nx(4);
      por = 1'h0;
      nx(8);
      rd(16, 9'h140, 9'h1ff);
      rd(16, 9'h040, 9'h1ff);
      nx(1);
      s_high = 1'h0;
      $display("status test done");
      for (s = 1; s <= 4; s++) begin
         go(16, 2'h2, s[2:0], 9'h1ff);
      end
      rd(16, 9'h000, 9'h1ff);
      for (s = 1; s <= 4; s++) begin
         go(16, 2'h0, 3'h0, {4'h0, 2'h2, s[2:0]});
         rd(16, msk[s], 9'h1ff);
      end
      go(16, 2'h0, 3'h0, 9'h009);
      rd(16, 9'h000, 9'h1ff);
      go(16, 2'h0, 3'h5, 9'h1ff);
      go(16, 2'h0, 3'h0, 9'h005);
      rd(16, 9'h1fd, 9'h1ff);
      $display("settings test done");
      nx(1);
      diag = 3'h5;
      go(16, 2'h0, 3'h0, 9'h007);
      rd(16, 9'h005, 9'h1ff);
      nx(1);
      diag = 3'h2;
      rd(16, 9'h002, 9'h1ff);
      nx(1);
      par    = 4'ha;
      wd_act = 1'h1;
      go(16, 2'h0, 3'h0, 9'h00f);
      rd(16, 9'h015, 9'h1ff);
      nx(1);
      fs     = 1'h1;
      fs_out = 4'h5;
      nx(8);
      rd(16, 9'h00b, 9'h1ff);
      $display("diagnostic test done");
      go(16, 2'h0, 3'h0, 9'h017);
      rd(16, 9'h004, 9'h1fc);
      go(8, 2'h0, 3'h0, 9'h007);
      go(24, 2'h3, 3'h1, 9'h1ff);
      rd(32, 9'h004, 9'h1fc);
      chk({7'h0, cfg[3].duty}, 16'h0000);
      $display("frame length test done");
      end_of_test();
   end
endmodule : xsr_readback_test

bind xsr_readback xsr_readback_checker u_chk (
   .sys_clk_in,
   .rst_in,
   .spi_cs_n_in,
   .spi_miso_out,
   .spi_miso_oe_n_out,
   .supply_low_fault_in,
   .supply_high_fault_in,
   .fault_register_in,
   .chan_cfg_out,
   .global_setup_reg_out,
   .fault_flag_pin_n_out
);
